// *** lmtc_los_mute.sv ***
// los mute, threshold select and interrupt pin sharing for a three-channel receiver
// assumes recovered words arrive in the system clock domain with valid/ready
`timescale 1ns/1ns

// ==========================================================
// fifo: parameterised, registered flags
module lmtc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys_i,   // system clock
    input  wire logic             sys_rst_i,   // synchronous reset, high
    input  wire logic             in_valid_i,  // write request
    output logic                  in_ready_o,  // room for a word
    input  wire logic [WIDTH-1:0] in_data_i,   // write data
    output logic                  out_valid_o, // word available
    input  wire logic             out_ready_i, // read request
    output logic [WIDTH-1:0]      out_data_o   // head word
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_CNT = DEPTH[AW:0];

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg, wr_ptr_next;
    logic [AW-1:0]    rd_ptr_reg, rd_ptr_next;
    logic [AW:0]      cnt_reg,    cnt_next;
    logic             rdy_reg,    rdy_next;
    logic             vld_reg,    vld_next;
    logic             do_wr;
    logic             do_rd;

    // pointer and flag updates; flags registered so ports come from flops
    always_comb begin
        do_wr       = in_valid_i & rdy_reg;
        do_rd       = out_ready_i & vld_reg;
        wr_ptr_next = do_wr ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
        rd_ptr_next = do_rd ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
        cnt_next    = cnt_reg;
        if (do_wr && !do_rd) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (do_rd && !do_wr) begin
            cnt_next = cnt_reg - 1'b1;
        end
        rdy_next = (cnt_next != DEPTH_CNT);
        vld_next = (cnt_next != '0);
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg    <= '0;
            rdy_reg    <= 1'b0;
            vld_reg    <= 1'b0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            cnt_reg    <= cnt_next;
            rdy_reg    <= rdy_next;
            vld_reg    <= vld_next;
        end
    end

    // storage has no reset; only read behind a valid count
    always_ff @(posedge clk_sys_i) begin
        if (do_wr) begin
            mem[wr_ptr_reg] <= in_data_i;
        end
    end

    assign in_ready_o  = rdy_reg;
    assign out_valid_o = vld_reg;
    assign out_data_o  = mem[rd_ptr_reg];
endmodule

// ==========================================================
// top: recovered data path with global mute and threshold control
module lmtc_los_mute (
    input  wire logic                   clk_sys_i,           // 100 MHz system clock
    input  wire logic                   sys_rst_i,           // synchronous reset, high
    input  wire logic                   rx_valid_i,          // recovered word offered
    output logic                        rx_ready_o,          // buffer can take a word
    input  wire lmtc_pkg::lmtc_rx_word_s rx_word_i,           // data and loss flags
    input  wire logic                   host_mode_i,         // high: serial host mode
    input  wire logic                   host_irq_i,          // interrupt from serial block
    input  wire logic                   mute_on_los_select_i, // shared pin, input side
    output logic                        mute_on_los_select_o, // shared pin, output side
    output logic                        mute_on_los_select_oe_o, // high while driving
    input  wire logic                   los_threshold_select_i, // threshold set pin
    input  wire lmtc_pkg::lmtc_rate_e   rate_i [lmtc_pkg::NUM_CH], // rate per channel
    input  wire logic                   rclk_edge_sel_i,     // high: update on rising
    output logic                        thr_set_o,           // threshold set in use
    output logic                        thr_active_o,        // threshold select honoured
    output logic [lmtc_pkg::NUM_CH-1:0] recovered_positive_data_o, // positive rail
    output logic [lmtc_pkg::NUM_CH-1:0] recovered_negative_data_o, // negative rail
    output logic [lmtc_pkg::NUM_CH-1:0] recovered_clock_out_o      // recovered clock
);
    import lmtc_pkg::*;

    // ==========================================================
    // declarations
    lmtc_rx_word_s      head_word;
    logic               head_valid;
    logic               upd;
    logic               mute_en;
    logic               any_fast;
    logic [3:0]         cnt_reg,  cnt_next;
    logic               rclk_reg, rclk_next;
    logic [NUM_CH-1:0]  pos_reg,  pos_next;
    logic [NUM_CH-1:0]  neg_reg,  neg_next;
    logic               thr_reg,  thr_next;
    logic               act_reg,  act_next;
    logic               pin_reg,  pin_next;
    logic               oe_reg,   oe_next;

    function automatic logic rate_is_fast(input lmtc_rate_e r);
        rate_is_fast = (r == LMTC_RATE_DS3) || (r == LMTC_RATE_STS1);
    endfunction

    // ==========================================================
    // buffer; drained once per bit period so it can really fill
    lmtc_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (rx_valid_i),
        .in_ready_o  (rx_ready_o),
        .in_data_i   (rx_word_i),
        .out_valid_o (head_valid),
        .out_ready_i (upd),
        .out_data_o  (head_word)
    );

    // ==========================================================
    // recovered clock divider and update edge
    always_comb begin
        cnt_next  = cnt_reg + 4'h1;
        rclk_next = rclk_reg;
        upd       = 1'b0;
        if (cnt_reg == RCLK_CNT_LAST) begin
            cnt_next  = 4'h0;
            rclk_next = ~rclk_reg;
            upd       = (~rclk_reg == rclk_edge_sel_i);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            cnt_reg  <= 4'h0;
            rclk_reg <= RST_RCLK;
        end else begin
            cnt_reg  <= cnt_next;
            rclk_reg <= rclk_next;
        end
    end

    // ==========================================================
    // data rails; mute only moves with the update edge, so no runt bits
    always_comb begin
        mute_en  = mute_on_los_select_i & ~host_mode_i;
        pos_next = pos_reg;
        neg_next = neg_reg;
        if (upd) begin
            if (head_valid) begin
                for (int c = 0; c < NUM_CH; c++) begin
                    pos_next[c] = head_word.pos[c] & ~(mute_en & head_word.los[c]);
                    neg_next[c] = head_word.neg[c] & ~(mute_en & head_word.los[c]);
                end
            end else begin
                pos_next = '0; // underrun: idle rails rather than stale bits
                neg_next = '0;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            pos_reg <= '0;
            neg_reg <= '0;
        end else begin
            pos_reg <= pos_next;
            neg_reg <= neg_next;
        end
    end

    // ==========================================================
    // threshold set; all-E3 freezes the last set since it is unused
    always_comb begin
        any_fast = 1'b0;
        for (int c = 0; c < NUM_CH; c++) begin
            any_fast = any_fast | rate_is_fast(rate_i[c]);
        end
        act_next = any_fast;
        thr_next = any_fast ? los_threshold_select_i : thr_reg;
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            thr_reg <= RST_THR_SET;
            act_reg <= 1'b0;
        end else begin
            thr_reg <= thr_next;
            act_reg <= act_next;
        end
    end

    // ==========================================================
    // shared pin: interrupt output in host mode, else input only
    always_comb begin
        oe_next  = host_mode_i;
        pin_next = host_irq_i ? ~IRQ_PIN_IDLE : IRQ_PIN_IDLE;
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            oe_reg  <= 1'b0;
            pin_reg <= IRQ_PIN_IDLE;
        end else begin
            oe_reg  <= oe_next;
            pin_reg <= pin_next;
        end
    end

    assign recovered_positive_data_o = pos_reg;
    assign recovered_negative_data_o = neg_reg;
    assign recovered_clock_out_o     = {NUM_CH{rclk_reg}};
    assign thr_set_o                 = thr_reg;
    assign thr_active_o              = act_reg;
    assign mute_on_los_select_o      = pin_reg;
    assign mute_on_los_select_oe_o   = oe_reg;

    // ==========================================================
    // checks
    for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
        AST_MUTE_ZERO: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
            upd && head_valid && mute_en && head_word.los[g] |=> !pos_reg[g] && !neg_reg[g])
            else $error("muted channel drove data");
        AST_PASS_THRU: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
            upd && head_valid && !mute_en |=> pos_reg[g] == $past(head_word.pos[g])
                && neg_reg[g] == $past(head_word.neg[g]))
            else $error("unmuted data not passed");
    end

    AST_GLOBAL_MUTE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        upd && head_valid && mute_en && (&head_word.los) |=> pos_reg == '0 && neg_reg == '0)
        else $error("mute not applied to every channel");
    AST_HOST_PIN: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        host_mode_i && host_irq_i |=> mute_on_los_select_oe_o && !mute_on_los_select_o)
        else $error("interrupt not on shared pin");
    AST_NO_DRIVE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        !host_mode_i |=> !mute_on_los_select_oe_o)
        else $error("shared pin driven outside host mode");
    AST_THR_FOLLOW: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        any_fast |=> thr_set_o == $past(los_threshold_select_i) && thr_active_o)
        else $error("threshold select not followed");
    AST_THR_IGNORE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        !any_fast |=> $stable(thr_set_o) && !thr_active_o)
        else $error("threshold select honoured in all-E3");
    AST_DATA_EDGE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        !$stable(pos_reg) || !$stable(neg_reg) |-> $past(upd) && rclk_reg == rclk_edge_sel_i)
        else $error("data moved off the update edge");
    AST_UPD_SPACING: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        upd |=> !upd [*3])
        else $error("update edges too close");
endmodule

// *** lmtc_pkg.sv ***
// shared constants and carriers for the loss-of-signal mute and threshold control
// assumes one 100 MHz system clock and synchronous pin inputs
package lmtc_pkg;

    // ==========================================================
    // geometry
    localparam int NUM_CH     = 3;                // channels under one global control
    localparam int FIFO_DEPTH = 16;               // words buffered ahead of the outputs

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;            // system clock period
    localparam int RCLK_HALF_NS  = 20;            // half period of the recovered clock model
    localparam int RCLK_HALF_INT = (RCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] RCLK_HALF_CYC  = RCLK_HALF_INT[3:0];
    localparam logic [3:0] RCLK_CNT_LAST  = RCLK_HALF_CYC - 4'h1;

    // ==========================================================
    // reset values and pin levels
    localparam logic EDGE_RISING   = 1'h1;        // edge select: update on rising edge
    localparam logic RST_RCLK      = 1'h0;        // recovered clock level after reset
    localparam logic RST_THR_SET   = 1'h0;        // threshold set after reset
    localparam logic IRQ_PIN_IDLE  = 1'h1;        // interrupt pin is active low

    // ==========================================================
    // line rate per channel
    typedef enum logic [1:0] {
        LMTC_RATE_E3   = 2'h0,
        LMTC_RATE_DS3  = 2'h1,
        LMTC_RATE_STS1 = 2'h2
    } lmtc_rate_e;

    // one bit period of recovered data for all channels, with loss flags
    typedef struct packed {
        logic [NUM_CH-1:0] los;                   // loss-of-signal declared
        logic [NUM_CH-1:0] neg;                   // negative rail
        logic [NUM_CH-1:0] pos;                   // positive rail
    } lmtc_rx_word_s;

    localparam int WORD_W = $bits(lmtc_rx_word_s);

endpackage

// *** lmtc_term_model.sv ***
// terminal equipment model: captures recovered rails once per bit period
// assumes rails and recovered clock are registers in the system clock domain
`timescale 1ns/1ns

// ==========================================================
// far-end receiver
module lmtc_term_model (
    input  wire logic       clk_sys_i,  // system clock
    input  wire logic       edge_sel_i, // high: capture on rising level change
    input  wire logic       rclk_i,     // recovered clock of channel 0
    input  wire logic [5:0] rails_i     // {neg, pos} of all channels
);
    logic [5:0] cap[$];                 // captured bit periods, oldest first
    logic       rclk_prev_reg = 1'b0;   // clock level seen one cycle ago

    // take one word per selected edge; rails stand a whole period so a late look is safe
    always @(posedge clk_sys_i) begin
        if (rclk_i !== rclk_prev_reg && rclk_i === edge_sel_i) begin
            cap.push_back(rails_i);
        end
        rclk_prev_reg <= rclk_i;
    end
endmodule

// *** test_lmtc_los_mute.sv ***
// self-checking bench for the los mute and threshold control
// assumes the design files and the terminal model are compiled ahead of it
`timescale 1ns/1ns

// ==========================================================
// bench top
module test_lmtc_los_mute;
    import lmtc_pkg::*;
    logic               clk_sys_i = 1'b0;
    logic               sys_rst_i = 1'b1;
    logic               rx_valid  = 1'b0;
    logic               host_mode = 1'b0;
    logic               host_irq  = 1'b0;
    logic               mute_sel  = 1'b0;
    logic               thr_sel   = 1'b0;
    logic               edge_sel  = 1'b1;
    lmtc_rx_word_s      rx_word   = '0;
    lmtc_rate_e         rate [NUM_CH] = '{LMTC_RATE_E3, LMTC_RATE_E3, LMTC_RATE_E3};
    logic               rx_ready, pin_o, pin_oe, thr_set, thr_active;
    logic [NUM_CH-1:0]  pos, neg, rclk;
    logic [5:0]         exp_q[$];
    lmtc_rx_word_s      w;
    logic [2:0]         m;
    int                 n_fail = 0;
    int                 comparisons = 0;
    int                 t;
    logic               saw_full;

    // clock
    always #(CLK_PERIOD_NS / 2) clk_sys_i = ~clk_sys_i;

    lmtc_los_mute lmtc_los_mute_i (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready),
        .rx_word_i(rx_word), .host_mode_i(host_mode), .host_irq_i(host_irq),
        .mute_on_los_select_i(mute_sel), .mute_on_los_select_o(pin_o), .mute_on_los_select_oe_o(pin_oe),
        .los_threshold_select_i(thr_sel), .rate_i(rate), .rclk_edge_sel_i(edge_sel),
        .thr_set_o(thr_set), .thr_active_o(thr_active), .recovered_positive_data_o(pos),
        .recovered_negative_data_o(neg), .recovered_clock_out_o(rclk));

    lmtc_term_model lmtc_term_model_i (
        .clk_sys_i(clk_sys_i), .edge_sel_i(edge_sel), .rclk_i(rclk[0]), .rails_i({neg, pos}));

    // ==========================================================
    // shared tasks
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    // offer a word and hold it until the buffer takes it; notes any refusal
    task automatic push(input lmtc_rx_word_s wd);
        int k;
        k = 0;
        rx_word  <= wd;
        rx_valid <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (rx_ready !== 1'b1) saw_full = 1'b1;
            k++;
        end while (rx_ready !== 1'b1 && k < 200);
        if (k >= 200) check("push_wait", 8'h0, 8'h1);
    endtask

    task automatic conclude();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // watchdog: the whole run needs well under 2000 cycles
    initial begin
        #200000;
        n_fail++;
        conclude();
    end

    // ==========================================================
    // main sequence
    initial begin
        tick(2);
        check("rst_rails", {2'h0, neg, pos}, 8'h00);
        check("rst_misc", {3'h0, rx_ready, pin_o, pin_oe, thr_set, thr_active}, 8'h08);
        sys_rst_i <= 1'b0;
        tick(2);
        // four mute/host/edge settings; each fills the buffer until it refuses, then drains
        for (int k = 0; k < 4; k++) begin
            // move the edge select only while the clock sits at the old unselected level;
            // a switch just after an update would give a two-cycle bit and trip the spacing check
            if (edge_sel !== (k < 2)) begin
                do begin
                    tick(1);
                end while (rclk[0] === edge_sel);
            end
            mute_sel  <= (k != 0);
            host_mode <= (k == 3);
            edge_sel  <= (k < 2);
            tick(8);
            lmtc_term_model_i.cap.delete();
            exp_q.delete();
            saw_full = 1'b0;
            // 24 words: pushing one a cycle against one drained every 4 cycles must reach 16 held
            for (int i = 0; i < 24; i++) begin
                w.los = 3'(i % 7);
                w.pos = 3'h5 ^ 3'(i);
                w.neg = ~w.pos;
                push(w);
                m = (k != 0 && k != 3) ? w.los : 3'h0;
                exp_q.push_back({w.neg & ~m, w.pos & ~m});
            end
            rx_valid <= 1'b0;
            check("refused_when_full", {7'h0, saw_full}, 8'h01);
            // leading underrun zeros are dropped; data words are never all zero
            t = 0;
            do begin
                tick(1);
                while (lmtc_term_model_i.cap.size() > 0 && lmtc_term_model_i.cap[0] === 6'h0)
                    void'(lmtc_term_model_i.cap.pop_front());
                t++;
            end while (lmtc_term_model_i.cap.size() < 24 && t < 400);
            for (int i = 0; i < 24; i++) begin
                check("rails", {2'h0, lmtc_term_model_i.cap[i]}, {2'h0, exp_q[i]});
            end
            tick(8);
            check("underrun", {2'h0, neg, pos}, 8'h00);
            check("drained", {7'h0, rx_ready}, 8'h01);
            check("clk_copies", {5'h0, rclk}, {5'h0, {3{rclk[0]}}});
        end
        // threshold select: ignored while every channel runs E3
        thr_sel <= 1'b1;
        tick(3);
        check("thr_all_e3", {6'h0, thr_set, thr_active}, 8'h00);
        rate[2] <= LMTC_RATE_STS1;
        tick(3);
        check("thr_sts1_hi", {6'h0, thr_set, thr_active}, 8'h03);
        thr_sel <= 1'b0;
        tick(3);
        check("thr_sts1_lo", {6'h0, thr_set, thr_active}, 8'h01);
        rate[2] <= LMTC_RATE_E3;
        rate[1] <= LMTC_RATE_DS3;
        thr_sel <= 1'b1;
        tick(3);
        check("thr_ds3_hi", {6'h0, thr_set, thr_active}, 8'h03);
        rate[1] <= LMTC_RATE_E3;
        thr_sel <= 1'b0;
        tick(3);
        check("thr_hold", {6'h0, thr_set, thr_active}, 8'h02);
        // shared pin turns into the active-low interrupt output in host mode
        host_mode <= 1'b1;
        host_irq  <= 1'b1;
        tick(3);
        check("irq_set", {6'h0, pin_oe, pin_o}, 8'h02);
        host_irq <= 1'b0;
        tick(3);
        check("irq_clear", {6'h0, pin_oe, pin_o}, 8'h03);
        host_mode <= 1'b0;
        tick(3);
        check("pin_input", {7'h0, pin_oe}, 8'h00);
        conclude();
    end
endmodule
